// ---- src/adc_ready_latch_cfg.svh ----
// Register offsets, field positions, reset values and timing counts of the
// converter front end register map.
// Assumes byte-wide registers addressed by a 5-bit serial address.
`ifndef ADC_READY_LATCH_CFG_SVH
`define ADC_READY_LATCH_CFG_SVH

// Byte offsets of the register map.
`define OFS_RESULT_A   5'h00
`define OFS_RESULT_B   5'h03
`define OFS_MOD        5'h06
`define OFS_DELAY      5'h07
`define OFS_DELAY_LO   5'h08
`define OFS_BIAS       5'h09
`define OFS_STATUS     5'h0a
`define OFS_STATUS_LO  5'h0b
`define OFS_SETUP      5'h0c
`define OFS_SETUP_LO   5'h0d
`define OFS_OFFSET_A   5'h0e
`define OFS_SCALE_A    5'h11
`define OFS_OFFSET_B   5'h14
`define OFS_SCALE_B    5'h17
`define OFS_DRIFT      5'h1a
`define OFS_LAST       5'h1a

// Field positions inside their byte.
`define POS_FLAGS      0
`define POS_SELECT     2
`define POS_DRIVE_HI   4
`define POS_WRITE_LOOP 5
`define POS_READ_LOOP  6
`define POS_OSR        3
`define POS_SHUTDOWN   4
`define POS_CHAN_RESET 6

// Reset values of the configuration bytes.
`define RST_MOD        8'h33
`define RST_BIAS       8'h80
`define RST_STATUS     8'h03
`define RST_STATUS_LO  8'hb8
`define RST_SETUP      8'h18
`define RST_ZERO       8'h00
`define RST_FLAGS      2'h3

// Master clock cycles in one modulator clock period.
`define MCLK_PER_MODCLK 3'h4
// Half the smallest oversampling ratio, in modulator clock periods.
`define OSR_MIN_HALF   13'h0010

`endif

// ---- src/adc_ready_latch_pkg.sv ----
// Types shared by the converter front end register map and its pin sampler.
// Assumes the constants of adc_ready_latch_cfg.svh for all numbers.
package adc_ready_latch_pkg;

  typedef struct packed {
    logic        done;
    logic [23:0] data;
  } conv_t;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic sdi;
  } spi_pins_t;

  typedef enum logic [2:0] {
    ST_CMD  = 3'b001,
    ST_DATA = 3'b010,
    ST_SKIP = 3'b100
  } spi_state_t;

  typedef enum logic [1:0] {
    SEL_LAG  = 2'b00,
    SEL_A    = 2'b01,
    SEL_B    = 2'b10,
    SEL_BOTH = 2'b11
  } ready_sel_t;

endpackage : adc_ready_latch_pkg

// ---- src/spi_pin_sampler.sv ----
// Two-flop synchroniser for the serial pins plus serial clock edge finder.
// Assumes the serial clock is at least four times slower than the master.
`timescale 1ns/100ps

module spi_pin_sampler (
  input  wire logic                          clk_in,
  input  wire logic                          reset_n_in,
  input  wire adc_ready_latch_pkg::spi_pins_t pins_in,
  output      adc_ready_latch_pkg::spi_pins_t pins_out,
  output      logic                          sck_rise_out,
  output      logic                          sck_fall_out
);

  adc_ready_latch_pkg::spi_pins_t meta;
  adc_ready_latch_pkg::spi_pins_t sync;
  logic                           sck_prev;
  adc_ready_latch_pkg::spi_pins_t next_meta;
  adc_ready_latch_pkg::spi_pins_t next_sync;
  logic                           next_sck_prev;

  // The idle levels keep a chip select high until a real frame arrives.
  always_comb begin
    next_meta     = pins_in;
    next_sync     = meta;
    next_sck_prev = sync.sck;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta     <= 3'b010;
      sync     <= 3'b010;
      sck_prev <= 1'b0;
    end else begin
      meta     <= next_meta;
      sync     <= next_sync;
      sck_prev <= next_sck_prev;
    end
  end

  assign pins_out     = sync;
  assign sck_rise_out = sync.sck & ~sck_prev;
  assign sck_fall_out = ~sync.sck & sck_prev;

endmodule : spi_pin_sampler

// ---- src/adc_ready_latch_regmap.sv ----
// Result latches, ready pin and byte register map of a two-channel
// converter front end, reached over a mode 0,0 serial port.
// Assumes the converter logic runs on the master clock, holds each result
// steady from its done pulse until the next one, and that the serial pins
// come from another clock domain.
`timescale 1ns/100ps
`include "adc_ready_latch_cfg.svh"

module adc_ready_latch_regmap #(
  // Serial device address; the value is arbitrary.
  parameter logic [1:0] DEVICE_ADDR = 2'b00
) (
  input  wire logic                       REF_CLK_IN,
  input  wire logic                       RESET_N_IN,
  input  wire logic                       SCK_IN,
  input  wire logic                       CS_N_IN,
  input  wire logic                       SDI_IN,
  output      logic                       SDO_OUT,
  output      logic                       SDO_OE_OUT,
  input  wire adc_ready_latch_pkg::conv_t CONV_A_IN,
  input  wire adc_ready_latch_pkg::conv_t CONV_B_IN,
  output      logic                       SAMPLE_READY_N_OUT,
  output      logic                       SAMPLE_READY_N_OE_OUT,
  output      logic [1:0]                 CHANNEL_HOLD_OUT
);

  // Channel A lags when its positive delay is within half a conversion.
  function automatic logic lag_is_a(input logic [11:0] ph,
                                    input logic [2:0]  oversampling_ratio);
    logic [12:0] mag;
    logic [12:0] half;
    mag  = ph[11] ? {1'b0, 12'(-ph)} : {1'b0, ph};
    half = `OSR_MIN_HALF << oversampling_ratio;
    if (ph == 12'h000) begin
      lag_is_a = 1'b0;
    end else begin
      lag_is_a = ph[11] ? (mag > half) : (mag <= half);
    end
  endfunction : lag_is_a

  // Next address of the byte counter for a loop mode.
  function automatic logic [4:0] loop_next(input logic [4:0] a,
                                           input logic [1:0] m);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = `OFS_RESULT_A;
    hi = `OFS_LAST;
    if (m == 2'b01) begin
      if (a >= `OFS_DRIFT) begin
        lo = `OFS_DRIFT;
        hi = `OFS_LAST;
      end else if (a >= `OFS_OFFSET_B) begin
        lo = `OFS_OFFSET_B;
        hi = `OFS_DRIFT - 5'h01;
      end else if (a >= `OFS_OFFSET_A) begin
        lo = `OFS_OFFSET_A;
        hi = `OFS_OFFSET_B - 5'h01;
      end else if (a >= `OFS_STATUS) begin
        lo = `OFS_STATUS;
        hi = `OFS_OFFSET_A - 5'h01;
      end else if (a >= `OFS_MOD) begin
        lo = `OFS_MOD;
        hi = `OFS_STATUS - 5'h01;
      end else if (a >= `OFS_RESULT_B) begin
        lo = `OFS_RESULT_B;
        hi = `OFS_MOD - 5'h01;
      end else begin
        hi = `OFS_RESULT_B - 5'h01;
      end
    end else if (m == 2'b10) begin
      lo = (a >= `OFS_MOD) ? `OFS_MOD : `OFS_RESULT_A;
      hi = (a >= `OFS_MOD) ? `OFS_LAST : `OFS_MOD - 5'h01;
    end
    if (m == 2'b00) begin
      loop_next = a;
    end else begin
      loop_next = (a >= hi) ? lo : a + 5'h01;
    end
  endfunction : loop_next

  function automatic logic [7:0] cfg_reset(input logic [4:0] a);
    unique case (a)
      `OFS_MOD:       cfg_reset = `RST_MOD;
      `OFS_BIAS:      cfg_reset = `RST_BIAS;
      `OFS_STATUS:    cfg_reset = `RST_STATUS;
      `OFS_STATUS_LO: cfg_reset = `RST_STATUS_LO;
      `OFS_SETUP:     cfg_reset = `RST_SETUP;
      default:        cfg_reset = `RST_ZERO;
    endcase
  endfunction : cfg_reset

  function automatic logic [7:0] result_byte(input logic [23:0] v,
                                             input logic [4:0]  idx);
    unique case (idx)
      5'h00:   result_byte = v[23:16];
      5'h01:   result_byte = v[15:8];
      default: result_byte = v[7:0];
    endcase
  endfunction : result_byte

  adc_ready_latch_pkg::spi_pins_t  pins;
  logic                            sck_rise;
  logic                            sck_fall;

  spi_pin_sampler u_pins (
    .clk_in       (REF_CLK_IN),
    .reset_n_in   (RESET_N_IN),
    .pins_in      ({SCK_IN, CS_N_IN, SDI_IN}),
    .pins_out     (pins),
    .sck_rise_out (sck_rise),
    .sck_fall_out (sck_fall)
  );

  logic [7:0]                       cfg      [`OFS_MOD:`OFS_LAST];
  logic [7:0]                       next_cfg [`OFS_MOD:`OFS_LAST];
  adc_ready_latch_pkg::spi_state_t  state;
  adc_ready_latch_pkg::spi_state_t  next_state;
  logic [2:0]                       bitcnt;
  logic [2:0]                       next_bitcnt;
  logic [6:0]                       rx;
  logic [6:0]                       next_rx;
  logic [7:0]                       tx;
  logic [7:0]                       next_tx;
  logic                             fresh;
  logic                             next_fresh;
  logic                             is_read;
  logic                             next_is_read;
  logic [4:0]                       addr;
  logic [4:0]                       next_addr;
  logic [23:0]                      res_a;
  logic [23:0]                      res_b;
  logic [23:0]                      next_res_a;
  logic [23:0]                      next_res_b;
  logic [23:0]                      snap_a;
  logic [23:0]                      snap_b;
  logic [23:0]                      next_snap_a;
  logic [23:0]                      next_snap_b;
  logic [1:0]                       lock;
  logic [1:0]                       next_lock;
  logic [1:0]                       flags;
  logic [1:0]                       next_flags;
  logic [2:0]                       pulse_cnt;
  logic [2:0]                       next_pulse_cnt;
  logic                             ready_n;
  logic                             next_ready_n;

  logic                             load_en;
  logic [4:0]                       load_addr;
  logic                             byte_read;
  logic                             wr_en;
  logic [7:0]                       wr_byte;
  logic [1:0]                       hold;
  logic [1:0]                       read_loop;
  logic                             write_loop;
  adc_ready_latch_pkg::ready_sel_t  sel;
  logic                             ev_a;
  logic                             ev_b;
  logic                             link_ev;
  logic                             cap_a;
  logic                             cap_b;
  logic                             trig;
  logic [1:0]                       lock_kept;
  logic [1:0]                       done;
  logic [23:0]                      view_a;
  logic [23:0]                      view_b;
  logic [7:0]                       load_byte;

  assign hold       = cfg[`OFS_SETUP_LO][`POS_CHAN_RESET +: 2] |
                      cfg[`OFS_SETUP_LO][`POS_SHUTDOWN +: 2];
  assign read_loop  = cfg[`OFS_STATUS_LO][`POS_READ_LOOP +: 2];
  assign write_loop = cfg[`OFS_STATUS_LO][`POS_WRITE_LOOP];
  assign sel        = adc_ready_latch_pkg::ready_sel_t'(
                        cfg[`OFS_STATUS][`POS_SELECT +: 2]);

  // Serial command, address counter and byte shifter.
  always_comb begin
    next_state   = state;
    next_bitcnt  = bitcnt;
    next_rx      = rx;
    next_tx      = tx;
    next_fresh   = fresh;
    next_is_read = is_read;
    next_addr    = addr;
    load_en      = 1'b0;
    load_addr    = addr;
    byte_read    = 1'b0;
    wr_en        = 1'b0;
    wr_byte      = {rx, pins.sdi};
    if (pins.cs_n) begin
      next_state  = adc_ready_latch_pkg::ST_CMD;
      next_bitcnt = 3'h0;
      next_fresh  = 1'b0;
    end else begin
      if (sck_fall) begin
        if (fresh) begin
          next_fresh = 1'b0;
        end else begin
          next_tx = {tx[6:0], 1'b0};
        end
      end
      if (sck_rise) begin
        next_rx     = {rx[5:0], pins.sdi};
        next_bitcnt = bitcnt + 3'h1;
        if (bitcnt == 3'h7) begin
          unique case (state)
            adc_ready_latch_pkg::ST_CMD: begin
              if (rx[6:5] == DEVICE_ADDR) begin
                next_state   = adc_ready_latch_pkg::ST_DATA;
                next_is_read = pins.sdi;
                next_addr    = rx[4:0];
                load_en      = pins.sdi;
                load_addr    = rx[4:0];
              end else begin
                next_state = adc_ready_latch_pkg::ST_SKIP;
              end
            end
            adc_ready_latch_pkg::ST_DATA: begin
              if (is_read) begin
                byte_read = 1'b1;
                next_addr = loop_next(addr, read_loop);
                load_en   = 1'b1;
                load_addr = next_addr;
              end else begin
                wr_en     = 1'b1;
                next_addr = loop_next(addr, {write_loop, 1'b0});
              end
            end
            adc_ready_latch_pkg::ST_SKIP: begin
              next_state = adc_ready_latch_pkg::ST_SKIP;
            end
          endcase
        end
      end
      if (load_en) begin
        next_tx    = load_byte;
        next_fresh = 1'b1;
      end
    end
  end

  // Second stage lock and result views.
  always_comb begin
    done[0]      = byte_read && addr == `OFS_RESULT_B - 5'h01;
    done[1]      = byte_read && addr == `OFS_MOD - 5'h01;
    // Lock ends only after the last byte.
    lock_kept    = lock & ~done;
    next_lock    = lock_kept;
    next_snap_a  = snap_a;
    next_snap_b  = snap_b;
    view_a       = lock_kept[0] ? snap_a : res_a;
    view_b       = lock_kept[1] ? snap_b : res_b;
    if (load_en && load_addr < `OFS_RESULT_B && !lock_kept[0]) begin
      next_lock[0] = 1'b1;
      next_snap_a  = res_a;
    end
    if (load_en && load_addr >= `OFS_RESULT_B && load_addr < `OFS_MOD &&
        !lock_kept[1]) begin
      next_lock[1] = 1'b1;
      next_snap_b  = res_b;
    end
    if (load_addr < `OFS_RESULT_B) begin
      load_byte = result_byte(view_a, load_addr);
    end else if (load_addr < `OFS_MOD) begin
      load_byte = result_byte(view_b, load_addr - `OFS_RESULT_B);
    end else if (load_addr <= `OFS_LAST) begin
      load_byte = cfg[load_addr];
      if (load_addr == `OFS_STATUS) begin
        load_byte[`POS_FLAGS +: 2] = flags;
      end
    end else begin
      load_byte = 8'h00;
    end
  end

  // Configuration bytes.
  always_comb begin
    for (int i = `OFS_MOD; i <= `OFS_LAST; i++) begin
      next_cfg[i] = cfg[i];
    end
    if (wr_en && addr >= `OFS_MOD && addr <= `OFS_LAST) begin
      next_cfg[addr] = wr_byte;
    end
  end

  // Completion events, first stage, flags and ready pulse.
  always_comb begin
    ev_a    = CONV_A_IN.done & ~hold[0];
    ev_b    = CONV_B_IN.done & ~hold[1];
    link_ev = (hold == 2'b00) &&
              (lag_is_a(
                 {cfg[`OFS_DELAY][3:0], cfg[`OFS_DELAY_LO]},
                 cfg[`OFS_SETUP][`POS_OSR +: 3]) ? CONV_A_IN.done
                                                 : CONV_B_IN.done);
    cap_a   = (sel == adc_ready_latch_pkg::SEL_LAG) ? link_ev : ev_a;
    cap_b   = (sel == adc_ready_latch_pkg::SEL_LAG) ? link_ev : ev_b;
    unique case (sel)
      adc_ready_latch_pkg::SEL_LAG:  trig = link_ev;
      adc_ready_latch_pkg::SEL_A:    trig = ev_a;
      adc_ready_latch_pkg::SEL_B:    trig = ev_b;
      adc_ready_latch_pkg::SEL_BOTH: trig = ev_a | ev_b;
    endcase
    next_res_a = cap_a ? CONV_A_IN.data : res_a;
    next_res_b = cap_b ? CONV_B_IN.data : res_b;
    // New data wins over a finished read.
    next_flags = (flags | done) & ~{cap_b, cap_a};
    if (trig) begin
      next_pulse_cnt = `MCLK_PER_MODCLK;
    end else if (pulse_cnt != 3'h0) begin
      next_pulse_cnt = pulse_cnt - 3'h1;
    end else begin
      next_pulse_cnt = pulse_cnt;
    end
    next_ready_n = (next_pulse_cnt == 3'h0);
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      for (int i = `OFS_MOD; i <= `OFS_LAST; i++) begin
        cfg[i] <= cfg_reset(5'(i));
      end
      state     <= adc_ready_latch_pkg::ST_CMD;
      bitcnt    <= 3'h0;
      rx        <= 7'h00;
      tx        <= 8'h00;
      fresh     <= 1'b0;
      is_read   <= 1'b0;
      addr      <= 5'h00;
      res_a     <= 24'h000000;
      res_b     <= 24'h000000;
      snap_a    <= 24'h000000;
      snap_b    <= 24'h000000;
      lock      <= 2'h0;
      flags     <= `RST_FLAGS;
      pulse_cnt <= 3'h0;
      ready_n   <= 1'b1;
    end else begin
      for (int i = `OFS_MOD; i <= `OFS_LAST; i++) begin
        cfg[i] <= next_cfg[i];
      end
      state     <= next_state;
      bitcnt    <= next_bitcnt;
      rx        <= next_rx;
      tx        <= next_tx;
      fresh     <= next_fresh;
      is_read   <= next_is_read;
      addr      <= next_addr;
      res_a     <= next_res_a;
      res_b     <= next_res_b;
      snap_a    <= next_snap_a;
      snap_b    <= next_snap_b;
      lock      <= next_lock;
      flags     <= next_flags;
      pulse_cnt <= next_pulse_cnt;
      ready_n   <= next_ready_n;
    end
  end

  // The pin floats when idle unless the drive-high bit is set, so several
  // devices can share one pulled-up ready line.
  assign SAMPLE_READY_N_OUT    = ready_n;
  assign SAMPLE_READY_N_OE_OUT = ~ready_n | cfg[`OFS_STATUS][`POS_DRIVE_HI];
  assign SDO_OUT               = tx[7];
  assign SDO_OE_OUT            = ~pins.cs_n;
  assign CHANNEL_HOLD_OUT      = hold;

endmodule : adc_ready_latch_regmap

// ---- test/adc_ready_latch_regmap_monitor.sv ----
// Checker for the ready pin and the serial output enable.
// Assumes binding to the register map top; sees its ports only.
`timescale 1ns/100ps
module adc_ready_latch_regmap_monitor (
  input wire logic                       REF_CLK_IN,
  input wire logic                       RESET_N_IN,
  input wire logic                       CS_N_IN,
  input wire logic                       SDO_OE_OUT,
  input wire adc_ready_latch_pkg::conv_t CONV_A_IN,
  input wire adc_ready_latch_pkg::conv_t CONV_B_IN,
  input wire logic                       SAMPLE_READY_N_OUT,
  input wire logic                       SAMPLE_READY_N_OE_OUT,
  input wire logic [1:0]                 CHANNEL_HOLD_OUT
);
  // Cycles since the last completion; saturates so it never wraps.
  logic [2:0] since;
  logic [2:0] next_since;
  always_comb begin
    next_since = (since == 3'h7) ? since : since + 3'h1;
    if (CONV_A_IN.done || CONV_B_IN.done) next_since = 3'h0;
  end
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
    if (!RESET_N_IN) since <= 3'h7;
    else since <= next_since;
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  sequence s_low4;
    !SAMPLE_READY_N_OUT [*4];
  endsequence
  sequence s_cs_open;
    $fell(CS_N_IN) ##1 !CS_N_IN [*3];
  endsequence
  property p_width;
    $fell(SAMPLE_READY_N_OUT) |-> s_low4;
  endproperty
  a_width: assert property (p_width)
    else $error("ready pulse shorter than four cycles");
  property p_cause;
    !SAMPLE_READY_N_OUT |-> since <= 3'h3;
  endproperty
  a_cause: assert property (p_cause)
    else $error("ready pin low too long after last event");
  property p_quiet;
    !CONV_A_IN.done && !CONV_B_IN.done && SAMPLE_READY_N_OUT
      |=> SAMPLE_READY_N_OUT;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("ready pulse without a completion event");
  property p_held;
    ((CONV_A_IN.done && CHANNEL_HOLD_OUT[0] && !CONV_B_IN.done) ||
     (CONV_B_IN.done && CHANNEL_HOLD_OUT[1] && !CONV_A_IN.done)) &&
    SAMPLE_READY_N_OUT |=> SAMPLE_READY_N_OUT;
  endproperty
  a_held: assert property (p_held)
    else $error("ready pulse from a held channel");
  property p_oe;
    !SAMPLE_READY_N_OUT |-> SAMPLE_READY_N_OE_OUT;
  endproperty
  a_oe: assert property (p_oe)
    else $error("ready pin low but not driven");
  property p_open;
    s_cs_open |-> SDO_OE_OUT;
  endproperty
  a_open: assert property (p_open)
    else $error("serial output not driven in frame");
  property p_close;
    CS_N_IN [*3] |-> !SDO_OE_OUT;
  endproperty
  a_close: assert property (p_close)
    else $error("serial output driven outside frame");
  property p_hold;
    $changed(CHANNEL_HOLD_OUT) |-> SDO_OE_OUT;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold bits changed outside a write frame");
endmodule : adc_ready_latch_regmap_monitor

bind adc_ready_latch_regmap adc_ready_latch_regmap_monitor i_mon (
  .REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN), .CS_N_IN(CS_N_IN),
  .SDO_OE_OUT(SDO_OE_OUT), .CONV_A_IN(CONV_A_IN), .CONV_B_IN(CONV_B_IN),
  .SAMPLE_READY_N_OUT(SAMPLE_READY_N_OUT),
  .SAMPLE_READY_N_OE_OUT(SAMPLE_READY_N_OE_OUT),
  .CHANNEL_HOLD_OUT(CHANNEL_HOLD_OUT));

// ---- test/spi_host_model.sv ----
// Serial host model: mode 0,0 frames of a command byte and data bytes.
// Assumes the master clock as timebase; pins change just after its edge.
`timescale 1ns/100ps
module spi_host_model (
  input  wire logic       clk_in,
  input  wire logic       sdo_in,
  output      logic       sck_out,
  output      logic       cs_n_out,
  output      logic       sdi_out,
  output      logic [7:0] rd_byte_out
);
  // Idle half periods between bytes; nonzero makes a slow host.
  int   gap = 0;
  event got;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
    rd_byte_out = 8'h00;
  end
  task automatic half();
    repeat (4) @(posedge clk_in);
    #1;
  endtask : half
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi_out = tx[i];
      half();
      rx[i] = sdo_in;
      sck_out = 1'b1;
      half();
      sck_out = 1'b0;
    end
  endtask : xbyte
  task automatic frame(input logic [4:0] a, input logic rd, input int n,
                       input logic [7:0] d);
    logic [7:0] rx;
    @(posedge clk_in);
    #1;
    cs_n_out = 1'b0;
    xbyte({2'b00, a, rd}, rx);
    for (int k = 0; k < n; k++) begin
      for (int g = 0; g < gap; g++) half();
      xbyte(d, rx);
      if (rd) begin
        rd_byte_out = rx;
        -> got;
      end
    end
    half();
    cs_n_out = 1'b1;
    // A released data line shows the inverse, so no stale bit can pass.
    sdi_out = ~sdi_out;
    half();
  endtask : frame
endmodule : spi_host_model

// ---- test/adc_ready_latch_regmap_test.sv ----
// Self-checking bench of the register map, ready pin and result latches.
// Assumes the host model drives the serial pins and reports read bytes.
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module adc_ready_latch_regmap_test;
  logic                       clk = 1'b0;
  logic                       rst_n, sck, cs_n, sdi, sdo, sdo_oe;
  logic                       rdy, rdy_oe, rdy_q;
  logic [1:0]                 hold;
  logic [7:0]                 rd_byte, e_byte;
  logic [7:0]                 exq[$];
  logic [23:0]                da, db, na, nb;
  adc_ready_latch_pkg::conv_t conv_a, conv_b;
  int                         n_errors = 0, n_checks = 0, n_pulse = 0;
  always #10 clk = ~clk;
  adc_ready_latch_regmap i_dut (
    .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .SCK_IN(sck), .CS_N_IN(cs_n),
    .SDI_IN(sdi), .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .CONV_A_IN(conv_a),
    .CONV_B_IN(conv_b), .SAMPLE_READY_N_OUT(rdy),
    .SAMPLE_READY_N_OE_OUT(rdy_oe), .CHANNEL_HOLD_OUT(hold));
  spi_host_model i_host (.clk_in(clk), .sdo_in(sdo_oe ? sdo : ~sdo),
    .sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi), .rd_byte_out(rd_byte));
  // The ready line is pulled up while the pin is not driven.
  always @(negedge clk) begin
    if (rdy_q === 1'b1 && (rdy | ~rdy_oe) === 1'b0) n_pulse++;
    rdy_q = rdy | ~rdy_oe;
  end
  always @(i_host.got) begin
    if (exq.size() == 0) begin
      n_errors++;
      $display("MISMATCH t=%0t unexpected byte", $time);
    end else begin
      e_byte = exq.pop_front();
      `CHK(rd_byte, e_byte)
    end
  end
  task automatic done(input logic [1:0] m);
    conv_a.done = m[0];
    conv_b.done = m[1];
    @(posedge clk);
    #1;
    conv_a.done = 1'b0;
    conv_b.done = 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask : done
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_host.frame(a, 1'b0, 1, d);
  endtask : wr
  task automatic rd(input logic [4:0] a, input int n);
    i_host.frame(a, 1'b1, n, 8'h00);
  endtask : rd
  task automatic stop_test();
    $display("TB: %0d errors, %0d checks", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    #1000000;
    n_errors++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    rdy_q = 1'b1;
    conv_a = '0;
    conv_b = '0;
    void'($urandom(88));
    {da, db, na, nb} = {$urandom(), $urandom(), $urandom()};
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    exq = {8'h33, 8'h00, 8'h00, 8'h80, 8'h03, 8'hb8, 8'h18, 8'h00};
    repeat (13) exq.push_back(8'h00);
    exq.push_back(8'h33);
    rd(5'h06, 22);
    conv_a.data = da;
    conv_b.data = db;
    done(2'b01);
    `CHK(n_pulse, 0)
    `CHK(rdy_oe, 1'b0)
    done(2'b10);
    `CHK(n_pulse, 1)
    exq = {8'h00, da[23:16], da[15:8], da[7:0]};
    rd(5'h0a, 1);
    fork
      rd(5'h00, 3);
      begin
        repeat (100) @(posedge clk);
        #1;
        conv_a.data = na;
        conv_b.data = nb;
        done(2'b01);
        done(2'b10);
      end
    join
    exq = {na[23:16], na[15:8], na[7:0], nb[23:16], nb[15:8], nb[7:0]};
    rd(5'h00, 6);
    exq = {8'h03};
    rd(5'h0a, 1);
    wr(5'h08, 8'h01);
    n_pulse = 0;
    done(2'b10);
    `CHK(n_pulse, 0)
    done(2'b01);
    `CHK(n_pulse, 1)
    wr(5'h07, 8'h0f);
    wr(5'h08, 8'hff);
    n_pulse = 0;
    done(2'b01);
    `CHK(n_pulse, 0)
    done(2'b10);
    `CHK(n_pulse, 1)
    wr(5'h08, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(5'h0a, {4'h1, s[1:0], 2'b00});
      n_pulse = 0;
      done(2'b01);
      `CHK(n_pulse, (s == 2) ? 0 : 1)
      done(2'b10);
      `CHK(n_pulse, (s == 3) ? 2 : 1)
      `CHK(rdy_oe, 1'b1)
    end
    wr(5'h0d, 8'h40);
    `CHK(hold, 2'b01)
    n_pulse = 0;
    done(2'b01);
    done(2'b10);
    `CHK(n_pulse, 1)
    wr(5'h0a, 8'h10);
    wr(5'h0d, 8'h20);
    `CHK(hold, 2'b10)
    n_pulse = 0;
    done(2'b01);
    done(2'b10);
    `CHK(n_pulse, 0)
    wr(5'h0d, 8'h00);
    wr(5'h00, 8'h5a);
    i_host.frame(5'h0e, 1'b0, 3, 8'h5a);
    exq = {na[23:16], na[15:8], na[7:0], 8'h5a, 8'h5a, 8'h5a, 8'h00, 8'h00};
    rd(5'h00, 3);
    rd(5'h0e, 4);
    rd(5'h1f, 1);
    wr(5'h0b, 8'h18);
    i_host.frame(5'h11, 1'b0, 2, 8'h3c);
    exq = {8'h3c, 8'h3c, 8'h00, 8'h80, 8'h33};
    rd(5'h11, 2);
    rd(5'h12, 1);
    wr(5'h0b, 8'h58);
    rd(5'h09, 2);
    wr(5'h0b, 8'hd8);
    i_host.gap = 3;
    exq = {8'h00, na[23:16], na[15:8], na[7:0]};
    rd(5'h1a, 4);
    `CHK(exq.size(), 0)
    stop_test();
  end
endmodule : adc_ready_latch_regmap_test
